// >>> core/setpoint_output_control.sv
// setpoint_output_control: sixteen setpoints watching the acquisition stream and
// driving the port upper byte and two analog outputs, plus the setpoint state word
// assumes acq_tick pulses once per sample period, and configuration is held static
// while acquisition runs
`timescale 1ns/1ps
// Operation
// - per setpoint byte and mask update port
// - per setpoint 16-bit value to analog outputs
// - hysteresis: inside window leaves output unchanged
// - hysteresis: above forces first, below second
// - true/false mode writes on both transitions
// - port upper byte within period plus 250ns
// - analog output within period plus 1us
// - evaluate samples; respond at next tick
// - counters compared only as latched samples
// - 16-bit state word, setpoint 0 LSB
// - state bit is 1 while criterion met
// - target none, port upper, analog 0/1
// - true-only mode writes on false only for hysteresis
// - most recently met setpoint wins
// - counter setpoints compare low 16 bits
module setpoint_output_control
   import setpoint_pkg::*;
(
   input  wire logic                       clk_sys,             // system clock
   input  wire logic                       reset,               // sync reset, high
   input  wire logic                       acq_run,             // acquisition running
   input  wire logic                       acq_tick,            // sample clock tick pulse
   input  wire logic                       sample_valid,        // stream word present
   input  wire logic [CHAN_W-1:0]          sample_chan,         // stream word channel
   input  wire logic [SAMPLE_W-1:0]        sample_data,         // latched stream word
   input  wire logic                       port_wr,             // host port write
   input  wire logic [15:0]                port_wdata,          // host port value
   input  wire logic [NUM_SP*CHAN_W-1:0]   sp_chan,             // watched channel each
   input  wire logic [NUM_SP*3-1:0]        sp_crit,             // criterion each
   input  wire logic [NUM_SP*2-1:0]        sp_update,           // update mode each
   input  wire logic [NUM_SP*VAL_W-1:0]    sp_limit_a,          // high limit each
   input  wire logic [NUM_SP*VAL_W-1:0]    sp_limit_b,          // low limit each
   input  wire logic [NUM_SP*2-1:0]        sp_tgt_true,         // target on true/above
   input  wire logic [NUM_SP*2-1:0]        sp_tgt_false,        // target on false/below
   input  wire logic [NUM_SP*VAL_W-1:0]    sp_val_true,         // value on true/above
   input  wire logic [NUM_SP*VAL_W-1:0]    sp_val_false,        // value on false/below
   input  wire logic [NUM_SP*BYTE_W-1:0]   sp_mask_true,        // byte mask on true
   input  wire logic [NUM_SP*BYTE_W-1:0]   sp_mask_false,       // byte mask on false
   output logic [15:0]                     port_out,            // digital output port
   output logic [VAL_W-1:0]                analog_out_zero,     // analog channel 0 code
   output logic [VAL_W-1:0]                analog_out_one,      // analog channel 1 code
   output logic                            analog_zero_load,    // channel 0 update pulse
   output logic                            analog_one_load,     // channel 1 update pulse
   output logic [NUM_SP-1:0]               setpoint_state_word  // state word, sp0 in LSB
);
   logic [NUM_SP-1:0] met;
   logic [NUM_SP-1:0] rise;
   logic [NUM_SP-1:0] fall;

   // ======================================================================
   // setpoint evaluators
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SP; gi++) begin : g_sp
         setpoint_eval u_eval (
            .clk_sys      (clk_sys),
            .reset        (reset),
            .run          (acq_run),
            .sample_valid (sample_valid),
            .sample_chan  (sample_chan),
            .sample_low   (sample_data[VAL_W-1:0]),
            .cfg_chan     (sp_chan[gi*CHAN_W +: CHAN_W]),
            .cfg_crit     (crit_e'(sp_crit[gi*3 +: 3])),
            .limit_a      (sp_limit_a[gi*VAL_W +: VAL_W]),
            .limit_b      (sp_limit_b[gi*VAL_W +: VAL_W]),
            .met          (met[gi]),
            .rise         (rise[gi]),
            .fall         (fall[gi])
         );
      end
   endgenerate

   // ======================================================================
   // pending updates gathered between ticks
   logic [BYTE_W-1:0] pend_byte_reg, pend_byte_next;
   logic [BYTE_W-1:0] pend_mask_reg, pend_mask_next;
   logic [VAL_W-1:0]  pend_a0_reg,   pend_a0_next;
   logic [VAL_W-1:0]  pend_a1_reg,   pend_a1_next;
   logic              pend_a0v_reg,  pend_a0v_next;
   logic              pend_a1v_reg,  pend_a1v_next;

   logic [15:0]       port_reg,      port_next;
   logic [VAL_W-1:0]  a0_reg,        a0_next;
   logic [VAL_W-1:0]  a1_reg,        a1_next;
   logic              a0_load_reg,   a0_load_next;
   logic              a1_load_reg,   a1_load_next;
   logic [NUM_SP-1:0] state_reg,     state_next;

   // merged view: pending so far plus this cycle's detections; later wins
   logic [BYTE_W-1:0] mrg_byte;
   logic [BYTE_W-1:0] mrg_mask;
   logic [VAL_W-1:0]  mrg_a0;
   logic [VAL_W-1:0]  mrg_a1;
   logic              mrg_a0v;
   logic              mrg_a1v;

   always_comb begin
      logic              fire;
      target_e           tgt;
      logic [VAL_W-1:0]  val;
      logic [BYTE_W-1:0] msk;
      logic              hyst;
      update_e           mode;
      fire     = 1'b0;
      tgt      = TGT_NONE;
      val      = '0;
      msk      = '0;
      hyst     = 1'b0;
      mode     = UPD_NONE;
      mrg_byte = pend_byte_reg;
      mrg_mask = pend_mask_reg;
      mrg_a0   = pend_a0_reg;
      mrg_a1   = pend_a1_reg;
      mrg_a0v  = pend_a0v_reg;
      mrg_a1v  = pend_a1v_reg;
      // ascending index, so in one cycle the highest-numbered setpoint overwrites
      for (int i = 0; i < NUM_SP; i++) begin
         for (int s = 0; s < 2; s++) begin
            hyst = (crit_e'(sp_crit[i*3 +: 3]) == CRIT_HYSTERESIS);
            mode = update_e'(sp_update[i*2 +: 2]);
            if (s == 0) begin
               fire = rise[i] && (hyst || mode != UPD_NONE);
               tgt  = target_e'(sp_tgt_true[i*2 +: 2]);
               val  = sp_val_true[i*VAL_W +: VAL_W];
               msk  = sp_mask_true[i*BYTE_W +: BYTE_W];
            end else begin
               // false writes only in true/false or hysteresis
               fire = fall[i] && (hyst || mode == UPD_TRUE_FALSE);
               tgt  = target_e'(sp_tgt_false[i*2 +: 2]);
               val  = sp_val_false[i*VAL_W +: VAL_W];
               msk  = sp_mask_false[i*BYTE_W +: BYTE_W];
            end
            if (fire) begin
               unique case (tgt)
                  TGT_NONE: begin
                  end
                  TGT_PORT_HIGH: begin
                     mrg_byte = (mrg_byte & ~msk) | (val[BYTE_W-1:0] & msk);
                     mrg_mask = mrg_mask | msk;
                  end
                  TGT_ANALOG_0: begin
                     mrg_a0  = val;
                     mrg_a0v = 1'b1;
                  end
                  TGT_ANALOG_1: begin
                     mrg_a1  = val;
                     mrg_a1v = 1'b1;
                  end
               endcase
            end
         end
      end
   end

   // ======================================================================
   // apply at the acquisition tick
   always_comb begin
      pend_byte_next = mrg_byte;
      pend_mask_next = mrg_mask;
      pend_a0_next   = mrg_a0;
      pend_a1_next   = mrg_a1;
      pend_a0v_next  = mrg_a0v;
      pend_a1v_next  = mrg_a1v;
      port_next      = port_reg;
      a0_next        = a0_reg;
      a1_next        = a1_reg;
      a0_load_next   = 1'b0;
      a1_load_next   = 1'b0;
      state_next     = met;
      if (port_wr) begin
         port_next = port_wdata;
      end
      // one register stage after the tick, well inside allowance
      if (acq_tick) begin
         port_next[15:8] = (port_next[15:8] & ~mrg_mask) | (mrg_byte & mrg_mask);
         if (mrg_a0v) begin
            a0_next      = mrg_a0;
            a0_load_next = 1'b1;
         end
         if (mrg_a1v) begin
            a1_next      = mrg_a1;
            a1_load_next = 1'b1;
         end
         pend_mask_next = '0;
         pend_a0v_next  = 1'b0;
         pend_a1v_next  = 1'b0;
      end
      if (!acq_run) begin
         pend_mask_next = '0;
         pend_a0v_next  = 1'b0;
         pend_a1v_next  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pend_byte_reg <= '0;
         pend_mask_reg <= '0;
         pend_a0_reg   <= ANALOG_RESET;
         pend_a1_reg   <= ANALOG_RESET;
         pend_a0v_reg  <= 1'b0;
         pend_a1v_reg  <= 1'b0;
         port_reg      <= PORT_RESET;
         a0_reg        <= ANALOG_RESET;
         a1_reg        <= ANALOG_RESET;
         a0_load_reg   <= 1'b0;
         a1_load_reg   <= 1'b0;
         state_reg     <= STATE_RESET;
      end else begin
         pend_byte_reg <= pend_byte_next;
         pend_mask_reg <= pend_mask_next;
         pend_a0_reg   <= pend_a0_next;
         pend_a1_reg   <= pend_a1_next;
         pend_a0v_reg  <= pend_a0v_next;
         pend_a1v_reg  <= pend_a1v_next;
         port_reg      <= port_next;
         a0_reg        <= a0_next;
         a1_reg        <= a1_next;
         a0_load_reg   <= a0_load_next;
         a1_load_reg   <= a1_load_next;
         state_reg     <= state_next;
      end
   end

   assign port_out            = port_reg;
   assign analog_out_zero     = a0_reg;
   assign analog_out_one      = a1_reg;
   assign analog_zero_load    = a0_load_reg;
   assign analog_one_load     = a1_load_reg;
   assign setpoint_state_word = state_reg;

endmodule : setpoint_output_control

// >>> core/setpoint_pkg.sv
// setpoint output control: shared constants, field widths and mode encodings
// assumes one system clock at 250 MHz and an acquisition stream delivered one word a cycle
package setpoint_pkg;

   // ======================================================================
   // sizes
   localparam int NUM_SP   = 16;
   localparam int CHAN_W   = 5;
   localparam int VAL_W    = 16;
   localparam int BYTE_W   = 8;
   localparam int SAMPLE_W = 32;

   // ======================================================================
   // modes and targets
   typedef enum logic [2:0] {
      CRIT_BELOW_A   = 3'h0,
      CRIT_ABOVE_A   = 3'h1,
      CRIT_INSIDE    = 3'h2,
      CRIT_OUTSIDE   = 3'h3,
      CRIT_EQUAL_A   = 3'h4,
      CRIT_HYSTERESIS = 3'h5
   } crit_e;

   typedef enum logic [1:0] {
      UPD_NONE       = 2'h0,
      UPD_TRUE_ONLY  = 2'h1,
      UPD_TRUE_FALSE = 2'h2
   } update_e;

   typedef enum logic [1:0] {
      TGT_NONE       = 2'h0,
      TGT_PORT_HIGH  = 2'h1,
      TGT_ANALOG_0   = 2'h2,
      TGT_ANALOG_1   = 2'h3
   } target_e;

   // ======================================================================
   // reset values
   localparam logic [VAL_W-1:0]  ANALOG_RESET   = 16'h0000;
   localparam logic [15:0]       PORT_RESET     = 16'h0000;
   localparam logic [NUM_SP-1:0] STATE_RESET    = 16'h0000;

   // ======================================================================
   // timing: latency allowances beyond one sample period
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int PORT_XFER_MAX_PS = 250000;
   localparam int DAC_XFER_MAX_PS  = 1000000;
   // longest times round down
   localparam int PORT_XFER_CYC    = PORT_XFER_MAX_PS / CLK_PERIOD_PS;
   localparam int DAC_XFER_CYC     = DAC_XFER_MAX_PS / CLK_PERIOD_PS;
   // cycles from the applying tick to the output flip-flops
   localparam int APPLY_LAT_CYC    = 1;

endpackage : setpoint_pkg

// >>> core/setpoint_eval.sv
// setpoint_eval: one setpoint criterion evaluated on latched stream samples
// assumes sample words are already latched at the sample tick by the acquisition path
`timescale 1ns/1ps
module setpoint_eval
   import setpoint_pkg::*;
(
   input  wire logic              clk_sys,       // system clock
   input  wire logic              reset,         // sync reset, high
   input  wire logic              run,           // acquisition running
   input  wire logic              sample_valid,  // stream word present
   input  wire logic [CHAN_W-1:0] sample_chan,   // channel of word
   input  wire logic [VAL_W-1:0]  sample_low,    // low 16 bits of word
   input  wire logic [CHAN_W-1:0] cfg_chan,      // watched channel
   input  wire crit_e             cfg_crit,      // criterion
   input  wire logic [VAL_W-1:0]  limit_a,       // high limit
   input  wire logic [VAL_W-1:0]  limit_b,       // low limit
   output logic                   met,           // criterion state
   output logic                   rise,          // became true / above window
   output logic                   fall           // became false / below window
);
   logic met_reg,    met_next;
   logic primed_reg, primed_next;
   logic rise_reg,   rise_next;
   logic fall_reg,   fall_next;

   // ======================================================================
   // next state
   always_comb begin
      logic hit;
      logic above;
      logic below;
      hit         = 1'b0;
      above       = (sample_low > limit_a);
      below       = (sample_low < limit_b);
      met_next    = met_reg;
      primed_next = primed_reg;
      rise_next   = 1'b0;
      fall_next   = 1'b0;
      unique case (cfg_crit)
         CRIT_BELOW_A:    hit = (sample_low < limit_a);
         CRIT_ABOVE_A:    hit = above;
         CRIT_INSIDE:     hit = (sample_low > limit_b) && (sample_low < limit_a);
         CRIT_OUTSIDE:    hit = below || above;
         CRIT_EQUAL_A:    hit = (sample_low == limit_a);
         CRIT_HYSTERESIS: hit = above;
         default:         hit = 1'b0;
      endcase
      if (!run) begin
         met_next    = 1'b0;
         primed_next = 1'b0;
      end else if (sample_valid && sample_chan == cfg_chan) begin
         if (cfg_crit == CRIT_HYSTERESIS) begin
            // an inside sample at start forces nothing, so only a side sample primes
            primed_next = above || below || primed_reg;
            if (above && (!met_reg || !primed_reg)) begin
               met_next  = 1'b1;
               rise_next = 1'b1;
            end else if (below && (met_reg || !primed_reg)) begin
               met_next  = 1'b0;
               fall_next = 1'b1;
            end
         end else if (hit != met_reg) begin
            met_next  = hit;
            rise_next = hit;
            fall_next = !hit;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         met_reg    <= 1'b0;
         primed_reg <= 1'b0;
         rise_reg   <= 1'b0;
         fall_reg   <= 1'b0;
      end else begin
         met_reg    <= met_next;
         primed_reg <= primed_next;
         rise_reg   <= rise_next;
         fall_reg   <= fall_next;
      end
   end

   assign met  = met_reg;
   assign rise = rise_reg;
   assign fall = fall_reg;

endmodule : setpoint_eval

// >>> sim/setpoint_output_control_sva.sv
// setpoint_output_control_sva: port-level timing checks of the setpoint block
// assumes reset is held for at least two clock edges
`timescale 1ns/1ps
module setpoint_output_control_sva
(
   input wire logic                            clk_sys,             // system clock
   input wire logic                            reset,               // sync reset
   input wire logic                            acq_run,             // running
   input wire logic                            acq_tick,            // sample tick
   input wire logic                            sample_valid,        // word present
   input wire logic                            port_wr,             // host write
   input wire logic [15:0]                     port_wdata,          // host value
   input wire logic [15:0]                     port_out,            // port
   input wire logic [setpoint_pkg::VAL_W-1:0]  analog_out_zero,     // analog 0
   input wire logic [setpoint_pkg::VAL_W-1:0]  analog_out_one,      // analog 1
   input wire logic                            analog_zero_load,    // load 0
   input wire logic                            analog_one_load,     // load 1
   input wire logic [setpoint_pkg::NUM_SP-1:0] setpoint_state_word  // state word
);
   import setpoint_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ======================================================================
   // output timing
   a_lower_hold: assert property (!$past(port_wr) |-> $stable(port_out[7:0]))
      else $error("port lower byte moved without a host write");
   a_host_write: assert property (port_wr |=> port_out[7:0] == $past(port_wdata[7:0]))
      else $error("port lower byte differs from host write");
   a_upper_tick: assert property (!$past(acq_tick) && !$past(port_wr) |-> $stable(port_out[15:8]))
      else $error("port upper byte moved off a tick");
   a_load_tick: assert property (analog_zero_load || analog_one_load |-> $past(acq_tick))
      else $error("analog load without a preceding tick");
   a_zero_load: assert property (!$stable(analog_out_zero) |-> analog_zero_load)
      else $error("analog 0 changed without load pulse");
   a_one_load: assert property (!$stable(analog_out_one) |-> analog_one_load)
      else $error("analog 1 changed without load pulse");
   // ======================================================================
   // state word
   a_state_clear: assert property (!acq_run [*3] |-> setpoint_state_word == 16'h0000)
      else $error("state word not cleared while stopped");
   a_word_cause: assert property (!$stable(setpoint_state_word) |->
      $past(sample_valid, 2) || !$past(acq_run) || !$past(acq_run, 2))
      else $error("state word changed without a sample");
endmodule : setpoint_output_control_sva
bind setpoint_output_control setpoint_output_control_sva u_setpoint_output_control_sva (
   .clk_sys, .reset, .acq_run, .acq_tick, .sample_valid, .port_wr, .port_wdata, .port_out,
   .analog_out_zero, .analog_out_one, .analog_zero_load, .analog_one_load,
   .setpoint_state_word);

// >>> sim/stream_host.sv
// stream_host: host side of the acquisition stream, one watched word per group
// assumes the bench calls group() and reads status_seen after it returns
`timescale 1ns/1ps
module stream_host
(
   input  wire logic                            clk_sys,      // system clock
   input  wire logic [setpoint_pkg::NUM_SP-1:0] state_word,   // device state word
   output logic                                 sample_valid, // word present
   output logic [setpoint_pkg::CHAN_W-1:0]      sample_chan,  // word channel
   output logic [setpoint_pkg::SAMPLE_W-1:0]    sample_data,  // word value
   output logic                                 acq_tick,     // sample tick
   output logic [setpoint_pkg::NUM_SP-1:0]      status_seen   // state word of group
);
   import setpoint_pkg::*;
   initial begin
      sample_valid = 1'b0;
      sample_chan = 5'h00;
      sample_data = 32'h0000_0000;
      acq_tick = 1'b0;
      status_seen = 16'h0000;
   end
   // ======================================================================
   // one sample group; no output streaming is ever started alongside
   // no output streaming
   task automatic group(input logic [CHAN_W-1:0] ch, input logic [SAMPLE_W-1:0] d);
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_chan = ch;
      sample_data = d;
      @(negedge clk_sys);
      sample_chan = 5'h1F;
      sample_data = {16'h0000, state_word};
      @(negedge clk_sys);
      sample_valid = 1'b0;
      sample_data = ~sample_data;
      acq_tick = 1'b1;
      @(negedge clk_sys);
      acq_tick = 1'b0;
      status_seen = state_word;
      repeat (2) @(negedge clk_sys);
   endtask : group
endmodule : stream_host

// >>> sim/setpoint_output_control_tb.sv
// setpoint_output_control_tb: directed and random setpoint scenarios
// assumes stream_host and the bound checker are compiled alongside
`timescale 1ns/1ps
module setpoint_output_control_tb;
   import setpoint_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic acq_run = 1'b0;
   logic port_wr = 1'b0;
   logic [15:0] port_wdata = 16'h0000;
   logic [NUM_SP*CHAN_W-1:0] sp_chan = '0;
   logic [NUM_SP*3-1:0] sp_crit = '0;
   logic [NUM_SP*2-1:0] sp_update = '0, sp_tgt_true = '0, sp_tgt_false = '0;
   logic [NUM_SP*VAL_W-1:0] sp_limit_a = '0, sp_limit_b = '0, sp_val_true = '0, sp_val_false = '0;
   logic [NUM_SP*BYTE_W-1:0] sp_mask_true = '0, sp_mask_false = '0;
   logic sample_valid, acq_tick, m;
   logic [CHAN_W-1:0] sample_chan;
   logic [SAMPLE_W-1:0] sample_data, d;
   logic [15:0] port_out, a0, a1, e_a0 = '0, e_a1 = '0, e_pt = '0, e_sw = '0, r0, r1, r2, r3, r4;
   logic [15:0] sw, seen;
   logic [15:0] hv [6] = '{16'h2000, 16'h0800, 16'h2000, 16'h4000, 16'h2000, 16'h0500};
   int n_fail = 0;
   int checks_done = 0;
   always #2 clk_sys = ~clk_sys;
   setpoint_output_control u_setpoint_output_control (.clk_sys, .reset, .acq_run, .acq_tick,
      .sample_valid, .sample_chan, .sample_data, .port_wr, .port_wdata, .sp_chan, .sp_crit,
      .sp_update, .sp_limit_a, .sp_limit_b, .sp_tgt_true, .sp_tgt_false, .sp_val_true,
      .sp_val_false, .sp_mask_true, .sp_mask_false, .port_out, .analog_out_zero(a0),
      .analog_out_one(a1), .analog_zero_load(), .analog_one_load(), .setpoint_state_word(sw));
   stream_host u_stream_host (.clk_sys, .state_word(sw), .sample_valid, .sample_chan,
      .sample_data, .acq_tick, .status_seen(seen));
   // ======================================================================
   // helpers
   task automatic cfg(input int i, input logic [4:0] ch, input logic [2:0] cr,
      input logic [1:0] up, tt, tf, input logic [15:0] a, b, vt, vf, input logic [7:0] mt, mf);
      sp_chan[i*5+:5] = ch;
      sp_crit[i*3+:3] = cr;
      sp_update[i*2+:2] = up;
      sp_tgt_true[i*2+:2] = tt;
      sp_tgt_false[i*2+:2] = tf;
      sp_limit_a[i*16+:16] = a;
      sp_limit_b[i*16+:16] = b;
      sp_val_true[i*16+:16] = vt;
      sp_val_false[i*16+:16] = vf;
      sp_mask_true[i*8+:8] = mt;
      sp_mask_false[i*8+:8] = mf;
   endtask : cfg
   task automatic chk(input string nm, input logic [15:0] sv, ev);
      checks_done++;
      if (sv !== ev) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, ev, sv);
      end
   endtask : chk
   // masked bits take the byte, lower byte untouched
   function automatic logic [15:0] mrg(input logic [15:0] p, input logic [7:0] v, mk);
      return {(p[15:8] & ~mk) | (v & mk), p[7:0]};
   endfunction : mrg
   task automatic outs(input logic [15:0] s);
      chk("analog_out_zero", a0, e_a0);
      chk("analog_out_one", a1, e_a1);
      chk("port_out", port_out, e_pt);
      chk("state_word", s, e_sw);
   endtask : outs
   task automatic step(input logic [4:0] ch, input logic [31:0] v);
      u_stream_host.group(ch, v);
      outs(seen);
   endtask : step
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
   // ======================================================================
   // scenarios
   initial begin
      void'($urandom(37016));
      r0 = 16'($urandom());
      r1 = 16'($urandom());
      r2 = 16'($urandom());
      r3 = 16'($urandom());
      r4 = 16'($urandom());
      cfg(0, 1, CRIT_ABOVE_A, UPD_TRUE_ONLY, TGT_ANALOG_0, TGT_ANALOG_0, 16'h4000, 0, r0, 0, 0, 0);
      cfg(1, 2, CRIT_INSIDE, UPD_TRUE_FALSE, TGT_PORT_HIGH, TGT_PORT_HIGH, 16'h2000, 16'h1000,
         16'h0070, 16'h0030, 8'hF0, 8'h3C);
      cfg(2, 3, CRIT_HYSTERESIS, UPD_NONE, TGT_ANALOG_1, TGT_ANALOG_1, 16'h3000, 16'h1000,
         r1, r2, 0, 0);
      cfg(3, 5, CRIT_INSIDE, UPD_TRUE_ONLY, TGT_ANALOG_1, 0, 16'h0200, 16'h0100, 16'h1111, 0, 0, 0);
      cfg(4, 6, CRIT_INSIDE, UPD_TRUE_ONLY, TGT_ANALOG_1, 0, 16'h0200, 16'h0100, 16'h2222, 0, 0, 0);
      cfg(5, 4, CRIT_BELOW_A, UPD_TRUE_FALSE, TGT_ANALOG_0, TGT_ANALOG_0, 16'h8000, 0, r3, r4, 0, 0);
      cfg(6, 7, CRIT_ABOVE_A, UPD_TRUE_ONLY, TGT_NONE, TGT_NONE, 0, 0, 16'hFFFF, 16'hFFFF, 8'hFF, 8'hFF);
      cfg(7, 8, CRIT_OUTSIDE, UPD_TRUE_FALSE, TGT_PORT_HIGH, TGT_PORT_HIGH, 16'h3000, 16'h1000,
         16'h00AA, 16'h0055, 8'h0F, 8'hFF);
      cfg(8, 9, CRIT_EQUAL_A, UPD_TRUE_ONLY, TGT_ANALOG_0, 0, 16'h1234, 0, 16'hBEEF, 0, 0, 0);
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      acq_run = 1'b1;
      outs(sw);
      $display("test reset done");
      step(1, 32'h7FFF_1000);
      e_a0 = r0;
      e_sw = 16'h0001;
      step(1, 32'h0000_8000);
      e_sw = 16'h0000;
      step(1, 32'h0000_0100);
      $display("test true only done");
      port_wr = 1'b1;
      port_wdata = 16'hA5C3;
      @(negedge clk_sys);
      port_wr = 1'b0;
      e_pt = 16'hA5C3;
      e_pt = mrg(e_pt, 8'h70, 8'hF0);
      e_sw = 16'h0002;
      step(2, 32'h0000_1800);
      e_pt = mrg(e_pt, 8'h30, 8'h3C);
      e_sw = 16'h0000;
      step(2, 32'h0000_3000);
      $display("test port merge done");
      for (int k = 0; k < 6; k++) begin
         if (hv[k] < 16'h1000) begin
            e_a1 = r2;
            e_sw[2] = 1'b0;
         end else if (hv[k] > 16'h3000) begin
            e_a1 = r1;
            e_sw[2] = 1'b1;
         end
         step(3, {16'h0000, hv[k]});
      end
      $display("test hysteresis done");
      e_a1 = 16'h1111;
      e_sw[3] = 1'b1;
      step(5, 32'h0000_0150);
      e_a1 = 16'h2222;
      e_sw[4] = 1'b1;
      step(6, 32'h0000_0150);
      e_sw[3] = 1'b0;
      step(5, 32'h0000_0050);
      e_a1 = 16'h1111;
      e_sw[3] = 1'b1;
      step(5, 32'h0000_0150);
      e_sw[6] = 1'b1;
      step(7, 32'h0000_0005);
      e_pt = mrg(e_pt, 8'hAA, 8'h0F);
      e_sw[7] = 1'b1;
      step(8, 32'h0000_0800);
      e_pt = mrg(e_pt, 8'h55, 8'hFF);
      e_sw[7] = 1'b0;
      step(8, 32'h0000_2000);
      e_a0 = 16'hBEEF;
      e_sw[8] = 1'b1;
      step(9, 32'h5555_1234);
      e_sw[8] = 1'b0;
      step(9, 32'h0000_1235);
      $display("test shared target done");
      for (int k = 0; k < 24; k++) begin
         d = (k == 0) ? 32'h0000_7FFF : (k == 1) ? 32'h0000_8000 : $urandom();
         m = d[15:0] < 16'h8000;
         if (m !== e_sw[5]) begin
            e_a0 = m ? r3 : r4;
            e_sw[5] = m;
         end
         step(4, d);
      end
      $display("test random done");
      acq_run = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("state_word", sw, 16'h0000);
      acq_run = 1'b1;
      e_sw = 16'h0000;
      step(4, 32'h0000_9000);
      e_a0 = r3;
      e_sw = 16'h0020;
      step(4, 32'h0000_0001);
      $display("test stop done");
      summarize();
   end
endmodule : setpoint_output_control_tb
